// ### lmd_consts.svh
`ifndef LMD_CONSTS_SVH
`define LMD_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define LMD_OFF_CTRL      5'h00
`define LMD_OFF_STATUS    5'h04
`define LMD_OFF_ROW       5'h08
`define LMD_OFF_DATA_LO   5'h0C
`define LMD_OFF_DATA_HI   5'h10

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define LMD_CTRL_MODE_LSB 0
`define LMD_CTRL_HALF_BIT 2
`define LMD_CTRL_EN_BIT   3
`define LMD_RST_MODE      2'h3
`define LMD_RST_HALF      1'h0
`define LMD_RST_EN        1'h0

// ----------------------------------------------------------------
// drive level codes
// ----------------------------------------------------------------
`define LMD_LVL_VSS       2'h0
`define LMD_LVL_V13       2'h1
`define LMD_LVL_V23       2'h2
`define LMD_LVL_VLCD      2'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LMD_SEG_N         60
`define LMD_ROWS          4
`define LMD_FR_DIV        24
`define LMD_FR_LAST       5'h17
`define LMD_SLOT_MUX2     5'h0C
`define LMD_SLOT_MUX3     5'h08
`define LMD_SLOT_MUX4     5'h06
`define LMD_FR_HZ         64
`define LMD_CLK_HZ        125000000
`define LMD_OSC_HALF_CYC  (`LMD_CLK_HZ / (`LMD_FR_HZ * `LMD_FR_DIV * 2))

`endif

// ### lmd_pkg.sv
package lmd_pkg;

	typedef enum logic [1:0] {
		MODE_STATIC = 2'b00,
		MODE_MUX2   = 2'b01,
		MODE_MUX3   = 2'b10,
		MODE_MUX4   = 2'b11
	} lmd_mode_t;

	typedef enum logic [1:0] {
		RD_IDLE  = 2'b00,
		RD_FETCH = 2'b01,
		RD_DONE  = 2'b10
	} lmd_rd_t;

	typedef logic [1:0] lmd_lvl_t;

endpackage : lmd_pkg

// ### lmd_row_ram.sv
`timescale 1ns/1ps
module lmd_row_ram #(
	parameter int ROWS = 4,
	parameter int W    = 60
) (
	// clock and reset
	input  logic                    clk_i,
	input  logic                    rst_b_i,
	// bit-masked write port
	input  logic [$clog2(ROWS)-1:0] wr_row_i,
	input  logic [W-1:0]            wr_mask_i,
	input  logic [W-1:0]            wr_data_i,
	// read ports, data one cycle after address
	input  logic [$clog2(ROWS)-1:0] rd_a_row_i,
	output logic [W-1:0]            rd_a_data_o,
	input  logic [$clog2(ROWS)-1:0] rd_b_row_i,
	output logic [W-1:0]            rd_b_data_o
);

	typedef struct packed {
		logic [ROWS-1:0][W-1:0] mem;
		logic [W-1:0]           q_a;
		logic [W-1:0]           q_b;
	} lmd_ram_st_t;

	lmd_ram_st_t st_r;
	lmd_ram_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.mem[wr_row_i] = (st_r.mem[wr_row_i] & ~wr_mask_i) |
			(wr_data_i & wr_mask_i);
		st_nxt.q_a = st_r.mem[rd_a_row_i];
		st_nxt.q_b = st_r.mem[rd_b_row_i];
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rd_a_data_o = st_r.q_a;
	assign rd_b_data_o = st_r.q_b;

endmodule : lmd_row_ram

// ### lmd_drive.sv
// The register addresses and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`include "lmd_consts.svh"
// Functional notes
// - static mode: one backplane, two levels, no time slots.
// - 1:2 mode shares each frame between two backplane slots.
// - 1:2 mode runs half bias (three levels) or third bias (four).
// - 1:3 mode shares each frame between three backplane slots.
// - 1:4 mode shares each frame between four backplane slots.
// - 1:3 and 1:4 modes also accept half bias.
// - oscillator select low: internal oscillator times the drive.
// - internal oscillator is driven out on the clock pin.
// - oscillator select high: clock pin is the external clock input.
// - frame rate is the working clock divided by 24.
// - cascaded parts share the active-low sync line to stay aligned.
// - display register holds one RAM row bit per segment.
// - 60 segment outputs from slot timing and display register bits.
// - backplanes follow the mode; 1:4 gives four distinct slots.
// - 1:3 mode: fourth backplane copies the second.
// - 1:2 mode: first equals third, second equals fourth.
// - static mode: all four backplanes identical.
// - RAM row k drives segments during backplane k's slot.
// - after reset: 1:4 mode, display off, all backplane and segment outputs at supply level.
module lmd_drive #(
	parameter int SEG_N    = `LMD_SEG_N,
	parameter int OSC_HALF = `LMD_OSC_HALF_CYC
) (
	// clock and reset
	input  logic                       clk_i,
	input  logic                       rst_b_i,
	// avalon-mm slave
	input  logic [4:0]                 avs_address_i,
	input  logic                       avs_read_i,
	input  logic                       avs_write_i,
	input  logic [3:0]                 avs_byteenable_i,
	input  logic [31:0]                avs_writedata_i,
	output logic [31:0]                avs_readdata_o,
	output logic                       avs_waitrequest_o,
	// clock and cascade pins
	input  logic                       osc_sel_i,
	input  logic                       clk_pin_i,
	output logic                       clk_pin_o,
	output logic                       clk_pin_oe_o,
	input  logic                       sync_n_i,
	output logic                       sync_n_o,
	output logic                       sync_n_oe_o,
	// lcd drive levels
	output lmd_pkg::lmd_lvl_t [3:0]       backplane_outputs_o,
	output lmd_pkg::lmd_lvl_t [SEG_N-1:0] segment_outputs_o
);
	import lmd_pkg::*;

	localparam int OSC_W = $clog2(OSC_HALF + 1);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		lmd_mode_t                mode;
		logic                     half;
		logic                     en;
		logic [1:0]               row;
		logic [OSC_W-1:0]         osc_cnt;
		logic                     osc_clk;
		logic                     ext_prev;
		logic [4:0]               fcnt;
		logic                     pol;
		logic [SEG_N-1:0]         disp;
		lmd_rd_t                  rd;
		logic [31:0]              rdata;
		lmd_lvl_t [3:0]           bp;
		lmd_lvl_t [SEG_N-1:0]     seg;
	} lmd_drv_st_t;

	lmd_drv_st_t      st_r;
	lmd_drv_st_t      st_nxt;
	logic             tick;
	logic [4:0]       fcnt_inc;
	logic [1:0]       row_next;
	logic [1:0]       slot;
	logic [31:0]      be32;
	logic             wr_lo;
	logic             wr_hi;
	logic [SEG_N-1:0] ram_wmask;
	logic [SEG_N-1:0] ram_wdata;
	logic [SEG_N-1:0] ram_q_a;
	logic [SEG_N-1:0] ram_q_b;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [1:0] slot_of(input logic [4:0] cnt,
		input lmd_mode_t mode);
		logic [4:0] q;
		q = 5'h0;
		case (mode)
			MODE_MUX2: q = cnt / `LMD_SLOT_MUX2;
			MODE_MUX3: q = cnt / `LMD_SLOT_MUX3;
			MODE_MUX4: q = cnt / `LMD_SLOT_MUX4;
			default:   q = 5'h0;
		endcase
		return q[1:0];
	endfunction : slot_of

	// row whose slot selects backplane i
	function automatic logic [1:0] bp_row(input logic [1:0] i,
		input lmd_mode_t mode);
		case (mode)
			MODE_MUX4: return i;
			MODE_MUX3: return (i == 2'h3) ? 2'h1 : i;
			MODE_MUX2: return {1'b0, i[0]};
			default:   return 2'h0;
		endcase
	endfunction : bp_row

	function automatic logic [31:0] be_mask(input logic [3:0] be);
		return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction : be_mask

	// ----------------------------------------------------------------
	// working clock
	// ----------------------------------------------------------------
	// internal oscillator is a divider of clk_i; an external clock is
	// edge-detected, so it must be slower than half of clk_i
	assign tick = osc_sel_i ? (clk_pin_i & ~st_r.ext_prev)
		: ((st_r.osc_cnt == '0) & ~st_r.osc_clk);
	assign clk_pin_o    = st_r.osc_clk;
	assign clk_pin_oe_o = ~osc_sel_i;

	// ----------------------------------------------------------------
	// frame timing and cascade
	// ----------------------------------------------------------------
	assign fcnt_inc = (st_r.fcnt == `LMD_FR_LAST) ? 5'h00
		: 5'(st_r.fcnt + 5'h01);
	assign row_next = slot_of(fcnt_inc, st_r.mode);
	assign slot     = slot_of(st_r.fcnt, st_r.mode);
	// open drain: pulled low for the first slice of each frame while the display is enabled
	assign sync_n_o    = 1'b0;
	assign sync_n_oe_o = st_r.en & (st_r.fcnt == 5'h00);

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	assign be32  = be_mask(avs_byteenable_i);
	assign wr_lo = avs_write_i & (avs_address_i == `LMD_OFF_DATA_LO);
	assign wr_hi = avs_write_i & (avs_address_i == `LMD_OFF_DATA_HI);
	assign ram_wmask = wr_lo ? SEG_N'(be32)
		: (wr_hi ? SEG_N'({be32, 32'h0}) : '0);
	assign ram_wdata = wr_lo ? SEG_N'(avs_writedata_i)
		: SEG_N'({avs_writedata_i, 32'h0});
	// reads take two wait cycles so the ram's registered data is ready
	assign avs_waitrequest_o = avs_read_i & (st_r.rd != RD_DONE);
	assign avs_readdata_o    = st_r.rdata;

	lmd_row_ram #(
		.ROWS (`LMD_ROWS),
		.W    (SEG_N)
	) u_ram (
		.clk_i       (clk_i),
		.rst_b_i     (rst_b_i),
		.wr_row_i    (st_r.row),
		.wr_mask_i   (ram_wmask),
		.wr_data_i   (ram_wdata),
		.rd_a_row_i  (st_r.row),
		.rd_a_data_o (ram_q_a),
		.rd_b_row_i  (row_next),
		.rd_b_data_o (ram_q_b)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.ext_prev = clk_pin_i;
		if (st_r.osc_cnt == '0) begin
			st_nxt.osc_clk = ~st_r.osc_clk;
			st_nxt.osc_cnt = OSC_W'(OSC_HALF - 1);
		end else begin
			st_nxt.osc_cnt = OSC_W'(st_r.osc_cnt - 1'b1);
		end

		if (tick) begin
			// another part is at frame start: line up behind it
			if (!sync_n_i && st_r.fcnt != 5'h00) begin
				st_nxt.fcnt = 5'h01;
			end else begin
				st_nxt.fcnt = fcnt_inc;
				if (st_r.fcnt == `LMD_FR_LAST) begin
					st_nxt.pol = ~st_r.pol;
				end
			end
			st_nxt.disp = ram_q_b;
		end

		// drive levels, one cycle behind the timing state
		for (int i = 0; i < 4; i++) begin
			if (!st_r.en) begin
				st_nxt.bp[i] = `LMD_LVL_VLCD;
			end else if (bp_row(2'(i), st_r.mode) == slot) begin
				st_nxt.bp[i] = st_r.pol ? `LMD_LVL_VLCD
					: `LMD_LVL_VSS;
			end else if (st_r.half) begin
				st_nxt.bp[i] = `LMD_LVL_V13;
			end else begin
				st_nxt.bp[i] = st_r.pol ? `LMD_LVL_V13
					: `LMD_LVL_V23;
			end
		end
		for (int j = 0; j < SEG_N; j++) begin
			if (!st_r.en) begin
				st_nxt.seg[j] = `LMD_LVL_VLCD;
			end else if (st_r.disp[j]) begin
				st_nxt.seg[j] = st_r.pol ? `LMD_LVL_VSS
					: `LMD_LVL_VLCD;
			end else if (st_r.half || st_r.mode == MODE_STATIC) begin
				st_nxt.seg[j] = st_r.pol ? `LMD_LVL_VLCD
					: `LMD_LVL_VSS;
			end else begin
				st_nxt.seg[j] = st_r.pol ? `LMD_LVL_V23
					: `LMD_LVL_V13;
			end
		end

		// register writes
		if (avs_write_i && avs_byteenable_i[0]) begin
			case (avs_address_i)
				`LMD_OFF_CTRL: begin
					st_nxt.mode = lmd_mode_t'(avs_writedata_i[
						`LMD_CTRL_MODE_LSB +: 2]);
					st_nxt.half = avs_writedata_i[`LMD_CTRL_HALF_BIT];
					st_nxt.en   = avs_writedata_i[`LMD_CTRL_EN_BIT];
				end
				`LMD_OFF_ROW: st_nxt.row = avs_writedata_i[1:0];
				default: ;
			endcase
		end

		// register reads
		case (st_r.rd)
			RD_IDLE: begin
				if (avs_read_i) begin
					st_nxt.rd = RD_FETCH;
				end
			end
			RD_FETCH: begin
				st_nxt.rd = RD_DONE;
				case (avs_address_i)
					`LMD_OFF_CTRL: st_nxt.rdata = {28'h0, st_r.en,
						st_r.half, st_r.mode};
					`LMD_OFF_STATUS: st_nxt.rdata = {23'h0, osc_sel_i,
						st_r.pol, slot, st_r.fcnt};
					`LMD_OFF_ROW:     st_nxt.rdata = {30'h0, st_r.row};
					`LMD_OFF_DATA_LO: st_nxt.rdata = 32'(ram_q_a);
					`LMD_OFF_DATA_HI: st_nxt.rdata = 32'(ram_q_a >> 32);
					default:          st_nxt.rdata = 32'h0;
				endcase
			end
			RD_DONE: st_nxt.rd = RD_IDLE;
			default: st_nxt.rd = RD_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			st_r      <= '0;
			st_r.mode <= lmd_mode_t'(`LMD_RST_MODE);
			st_r.half <= `LMD_RST_HALF;
			st_r.en   <= `LMD_RST_EN;
			st_r.bp   <= {4{`LMD_LVL_VLCD}};
			st_r.seg  <= {SEG_N{`LMD_LVL_VLCD}};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign backplane_outputs_o = st_r.bp;
	assign segment_outputs_o   = st_r.seg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	chk_disabled_level: assert property (
		!st_r.en |=> backplane_outputs_o == {4{`LMD_LVL_VLCD}}
			&& segment_outputs_o[0] == `LMD_LVL_VLCD)
		else $error("disabled outputs not at supply level");

	chk_static_bp: assert property (
		st_r.en && st_r.mode == MODE_STATIC |=>
			backplane_outputs_o[1] == backplane_outputs_o[0]
			&& backplane_outputs_o[2] == backplane_outputs_o[0]
			&& backplane_outputs_o[3] == backplane_outputs_o[0])
		else $error("static backplanes differ");

	chk_mux2_pairs: assert property (
		st_r.en && st_r.mode == MODE_MUX2 |=>
			backplane_outputs_o[2] == backplane_outputs_o[0]
			&& backplane_outputs_o[3] == backplane_outputs_o[1])
		else $error("1:2 backplane pairs differ");

	chk_mux3_copy: assert property (
		st_r.en && st_r.mode == MODE_MUX3 |=>
			backplane_outputs_o[3] == backplane_outputs_o[1])
		else $error("1:3 fourth backplane not a copy");

	chk_mux4_distinct: assert property (
		st_r.en && st_r.mode == MODE_MUX4 && st_r.fcnt == 5'h00 |=>
			backplane_outputs_o[0] != backplane_outputs_o[1])
		else $error("1:4 slot not distinct");

	chk_frame_wrap: assert property (
		tick && sync_n_i && st_r.fcnt == `LMD_FR_LAST |=>
			st_r.fcnt == 5'h00 && st_r.pol != $past(st_r.pol))
		else $error("frame did not wrap after 24 ticks");

	chk_clk_drive: assert property (
		!osc_sel_i && tick |=> clk_pin_o && clk_pin_oe_o)
		else $error("internal clock not driven on pin");

	chk_sync_drive: assert property (
		st_r.en && tick && sync_n_i && st_r.fcnt == `LMD_FR_LAST
			|=> sync_n_oe_o && !sync_n_o)
		else $error("sync not pulled at frame start");

	chk_disp_load: assert property (
		tick |=> st_r.disp == $past(ram_q_b))
		else $error("display register missed its row");

	chk_half_levels: assert property (
		st_r.en && st_r.half |=> segment_outputs_o[0] inside
			{`LMD_LVL_VSS, `LMD_LVL_VLCD})
		else $error("half bias segment at third level");

	cov_mux4_wrap: cover property (
		st_r.mode == MODE_MUX4 && tick && st_r.fcnt == `LMD_FR_LAST);
	cov_mux3_half: cover property (
		st_r.en && st_r.mode == MODE_MUX3 && st_r.half && tick);
	cov_ext_tick: cover property (osc_sel_i && tick);
	cov_resync: cover property (tick && !sync_n_i && st_r.fcnt != 5'h00);

endmodule : lmd_drive

// ### lmd_panel.sv
`timescale 1ns/1ps
// --------------------
// passive glass: net dc of every segment/backplane pair over a window
// --------------------
module lmd_panel (
	// clock and window
	input  logic                        clk_i,
	input  logic                        win_i,
	input  logic                        half_i,
	// drive levels
	input  lmd_pkg::lmd_lvl_t [3:0]     bp_i,
	input  lmd_pkg::lmd_lvl_t [59:0]    seg_i,
	// result
	output logic                        dc_bad_o
);
	import lmd_pkg::*;
	int   acc [4][60];
	logic win_q = 1'b0;
	// volts in sixths of supply; half bias moves code 1 to mid-rail
	function automatic int volt(lmd_lvl_t c);
		return (c == 2'h1) ? (half_i ? 3 : 2) : (c == 2'h2) ? 4 : 2 * int'(c);
	endfunction : volt
	// a window restarts the sums, so stale frames never leak in
	always @(posedge clk_i) begin
		win_q <= win_i;
		for (int b = 0; b < 4; b++)
			for (int s = 0; s < 60; s++)
				if (win_i)
					acc[b][s] <= (win_q ? acc[b][s] : 0)
						+ volt(seg_i[s]) - volt(bp_i[b]);
	end
	always_comb begin
		dc_bad_o = 1'b0;
		for (int b = 0; b < 4; b++)
			for (int s = 0; s < 60; s++)
				if (acc[b][s] != 0)
					dc_bad_o = 1'b1;
	end
endmodule : lmd_panel

// ### lmd_drive_bench.sv
`timescale 1ns/1ps
`include "lmd_consts.svh"
module lmd_drive_bench;
	import lmd_pkg::*;
	// --------------------
	// signals and wiring
	// --------------------
	logic            clk_i = 1'b0;
	logic            rst_b_i = 1'b0;
	logic            osc_sel_i = 1'b0;
	logic            ext_clk = 1'b0;
	logic [1:0]      ecnt = 2'h0;
	logic            pull = 1'b0;
	logic            win = 1'b0;
	logic            half = 1'b0;
	logic [4:0]      adr = 5'h00;
	logic            rd = 1'b0;
	logic            wr = 1'b0;
	logic [31:0]     wdat = 32'h0;
	logic [31:0]     rdat;
	logic            wreq, cpo, cpoe, syo, syoe, syoe_q, dc_bad;
	lmd_lvl_t [3:0]  bp;
	lmd_lvl_t [59:0] seg;
	logic [59:0]     ram [4];
	int              err_total = 0;
	int              n_compared = 0;
	// shared clock pin: the part drives it unless strapped external
	wire             clk_pin = cpoe ? cpo : ext_clk;
	// open-drain sync with pull-up, also pulled by a cascade neighbour
	wire             sync_n = pull ? 1'b0 : (syoe ? syo : 1'b1);
	wire             rise = syoe & ~syoe_q;

	always #4 clk_i = ~clk_i;

	// neighbour clock source, six cycles a period, never stopped
	always @(posedge clk_i) begin
		syoe_q <= syoe;
		ecnt <= (ecnt == 2'h2) ? 2'h0 : ecnt + 2'h1;
		if (ecnt == 2'h2)
			ext_clk <= ~ext_clk;
	end

	lmd_drive #(.OSC_HALF(2)) uut (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(4'hF),
		.avs_writedata_i(wdat), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wreq), .osc_sel_i(osc_sel_i),
		.clk_pin_i(clk_pin), .clk_pin_o(cpo), .clk_pin_oe_o(cpoe),
		.sync_n_i(sync_n), .sync_n_o(syo), .sync_n_oe_o(syoe),
		.backplane_outputs_o(bp), .segment_outputs_o(seg)
	);

	lmd_panel glass (.clk_i(clk_i), .win_i(win), .half_i(half),
		.bp_i(bp), .seg_i(seg), .dc_bad_o(dc_bad));

	// --------------------
	// checking and bus tasks
	// --------------------
	task automatic results;
		if (err_total == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results

	task automatic chk(string n, logic [119:0] e, logic [119:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic chkn(string n, int e, int g);
		n_compared++;
		if (g != e) begin
			err_total++;
			$display("Error %s expected %0d seen %0d", n, e, g);
		end
	endtask : chkn

	// request held until the edge that sees waitrequest low
	task automatic bus(logic w, logic [4:0] a, logic [31:0] d,
		output logic [31:0] q);
		int k;
		k = 0;
		@(posedge clk_i);
		adr <= a;
		wdat <= d;
		wr <= w;
		rd <= ~w;
		do begin
			@(posedge clk_i);
			k++;
			if (k > 50) begin
				err_total++;
				results;
			end
		end while (wreq !== 1'b0);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus

	task automatic wrr(logic [4:0] a, logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wrr

	task automatic rdc(string n, logic [4:0] a, logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(n, 120'(e), 120'(q));
	endtask : rdc

	task automatic to_rise(output int k);
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
			if (k > 400) begin
				err_total++;
				results;
			end
		end while (rise !== 1'b1);
	endtask : to_rise

	// backplanes sharing the slot of lowest selected backplane r
	function automatic logic [3:0] mask(int m, int r);
		case (m)
			0: return 4'hF;
			1: return r[0] ? 4'hA : 4'h5;
			2: return (r == 1) ? 4'hA : 4'(1 << r);
			default: return 4'(1 << r);
		endcase
	endfunction : mask

	// two frames sampled each cycle from a frame start
	task automatic run(int m, logic h);
		lmd_lvl_t        c, u;
		lmd_lvl_t [3:0]  ebp;
		lmd_lvl_t [59:0] es;
		logic [3:0]      sel, em;
		int              r, n, rises, tog;
		int              cnt [4];
		logic            pcp;
		rises = 0;
		tog = 0;
		cnt = '{0, 0, 0, 0};
		wrr(`LMD_OFF_CTRL, {28'h0, 1'b1, h, 2'(m)});
		half <= h;
		to_rise(n);
		win <= 1'b1;
		n = (m == 0) ? 1 : m + 1;
		pcp = cpo;
		for (int j = 0; j < 192; j++) begin
			@(posedge clk_i);
			rises += int'(rise);
			tog += int'(cpo != pcp);
			pcp = cpo;
			for (int i = 0; i < 4; i++)
				sel[i] = (bp[i] == 2'h0 || bp[i] == 2'h3);
			r = sel[0] ? 0 : sel[1] ? 1 : sel[2] ? 2 : 3;
			c = bp[r];
			u = (h || c == 2'h3) ? 2'h1 : 2'h2;
			em = mask(m, r);
			cnt[r]++;
			for (int i = 0; i < 4; i++)
				ebp[i] = em[i] ? c : u;
			for (int s = 0; s < 60; s++)
				es[s] = ram[r][s] ? 2'h3 - c
					: (h || m == 0) ? c : (c == 2'h3 ? 2'h2 : 2'h1);
			chk("bp_sel", 120'(em), 120'(sel));
			chk("bp_lvl", 120'(ebp), 120'(bp));
			chk("seg", 120'(es), 120'(seg));
		end
		win <= 1'b0;
		chkn("rises", 2, rises);
		chkn("clk_tog", 96, tog);
		chk("clk_oe", 120'(1'b1), 120'(cpoe));
		for (int i = 0; i < 4; i++)
			chkn("slot", (i < n) ? 192 / n : 0, cnt[i]);
		@(posedge clk_i);
		chk("net_dc", 120'(1'b0), 120'(dc_bad));
	endtask : run

	// --------------------
	// main sequence
	// --------------------
	initial begin
		int n;
		logic [31:0] q;
		repeat (3) @(posedge clk_i);
		chk("bp_rst", 120'(8'hFF), 120'(bp));
		chk("seg_rst", {120{1'b1}}, 120'(seg));
		rst_b_i <= 1'b1; // reset released, the part runs from here on
		rdc("ctrl_rst", `LMD_OFF_CTRL, 32'h0000_0003);
		wrr(5'h14, 32'hFFFF_FFFF);
		rdc("unmapped", 5'h14, 32'h0000_0000);
		for (int r = 0; r < 4; r++) begin
			ram[r] = 60'h8C3_A5F0_1E2D_3B49 ^ {15{4'(1 << r)}};
			wrr(`LMD_OFF_ROW, 32'(r));
			wrr(`LMD_OFF_DATA_LO, ram[r][31:0]);
			wrr(`LMD_OFF_DATA_HI, {4'h0, ram[r][59:32]});
			rdc("data_lo", `LMD_OFF_DATA_LO, ram[r][31:0]);
			rdc("data_hi", `LMD_OFF_DATA_HI, {4'h0, ram[r][59:32]});
		end
		for (int m = 3; m >= 0; m--)
			for (int h = 0; h < 2; h++)
				run(m, 1'(h));
		// neighbour pulls sync for one tick in mid-frame
		to_rise(n);
		chk("sync_low", 120'(1'b0), 120'(sync_n));
		repeat (40) @(posedge clk_i);
		pull <= 1'b1;
		repeat (4) @(posedge clk_i);
		pull <= 1'b0;
		to_rise(n);
		chkn("resync", 1, int'(n >= 85 && n <= 100));
		bus(1'b0, `LMD_OFF_STATUS, 32'h0, q);
		chk("status_osc", 120'(1'b0), 120'(q[8]));
		chkn("status_fcnt", 1, int'(q[4:0] < `LMD_FR_DIV));
		osc_sel_i <= 1'b1;
		to_rise(n);
		chk("clk_oe_ext", 120'(1'b0), 120'(cpoe));
		to_rise(n);
		chkn("ext_frame", 144, n);
		bus(1'b0, `LMD_OFF_STATUS, 32'h0, q);
		chk("status_ext", 120'(1'b1), 120'(q[8]));
		results;
	end
endmodule : lmd_drive_bench
